/* pkg/tlc_regs.vh */
`ifndef TLC_REGS_VH
`define TLC_REGS_VH
// Register byte addresses
`define TLC_CTRL_ADDR      8'h00
`define TLC_STATUS_ADDR    8'h04
`define TLC_PT0_ADDR       8'h08
`define TLC_PT1_ADDR       8'h0c
`define TLC_PT2_ADDR       8'h10
`define TLC_PT3_ADDR       8'h14
`define TLC_PT4_ADDR       8'h18
// Point index is the word offset from the first point
`define TLC_WORD_SHIFT     2
// CTRL fields
`define TLC_CTRL_PUMPREQ   0
`define TLC_CTRL_XFERDONE  1
`define TLC_CTRL_RESET     32'h00000000
// Selector codes
`define TLC_SEL_TWO        4'h0
`define TLC_SEL_ULTRA      4'h1
`define TLC_SEL_LOW        4'ha
`define TLC_SEL_HIGH       4'hb
`define TLC_SEL_TX         4'hc
`define TLC_SEL_RX         4'hd
`define TLC_SEL_FIVE       4'hf
`define TLC_SEL_ID_LO      4'h2
`define TLC_SEL_ID_HI      4'h5
// Blink counts
`define TLC_BL_EMPTY2      5'd3
`define TLC_BL_EMPTY5      5'd6
`define TLC_BL_ERR         5'd12
`define TLC_BL_QUICK       5'd3
`define TLC_BL_ULTRA       5'd4
`define TLC_BL_QTR         5'd2
`define TLC_BL_HALF        5'd3
`define TLC_BL_TQTR        5'd4
`define TLC_BL_FULL5       5'd5
// Times
`define TLC_CLK_HZ         25000000
`define TLC_HOLD_MS        3000
`define TLC_DEB_MS         20
`define TLC_SLOW_MS        500
`define TLC_FAST_MS        60
`define TLC_XFER_MS        20000
`endif

/* rtl/tlc_tank_cal.v */
// Behaviour
// [R1] Closed valve inhibits pump start
// [R2] Pump request while closed raises alarm
// [R3] Link-to-sense-one continuity enables pump
// [R4] Selector 0, 3 s hold starts two-point
// [R5] Very fast blink until reading settles
// [R6] Empty captured: three slow blinks, LED on
// [R7] Next press: full stored, three blinks, off
// [R8] No empty/full difference: twelve slow blinks
// [R9] Selector A recaptures low point only
// [R10] Selector B recaptures high point only
// [R11] Single point: press saves, three quick blinks; code gives them at the slow blink rate
// [R12] Selector F five-point, six blinks, lit
// [R13] Second press quarter level, two blinks
// [R14] Third press half level, three blinks
// [R15] Fourth press three-quarter level, four blinks
// [R16] Fifth press full level, five blinks, off
// [R17] Selector C transmits calibration, blinking
// [R18] Selector D receives calibration, blinking
// [R19] Copying done with two units only
// [R20] Selector 1 hold: ultrasonic, four blinks
// [R21] Units take distinct selector 2 to 5
// [R22] Master display unit controls network traffic
// [R23] Button debounced, hold timed by counter
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_regs.vh"
module tlc_tank_cal #(
  parameter HOLD_CYC  = (`TLC_CLK_HZ / 1000) * `TLC_HOLD_MS,
  parameter DEB_CYC   = (`TLC_CLK_HZ / 1000) * `TLC_DEB_MS,
  parameter SLOW_CYC  = (`TLC_CLK_HZ / 1000) * `TLC_SLOW_MS,
  parameter FAST_CYC  = (`TLC_CLK_HZ / 1000) * `TLC_FAST_MS,
  parameter XFER_CYC  = (`TLC_CLK_HZ / 1000) * `TLC_XFER_MS,
  parameter LVL_W     = 12
) (
  input  wire             core_clk,     // 25 MHz clock
  input  wire             rst_b,        // Sync reset, active low
  input  wire             hsel,         // AHB select
  input  wire [7:0]       haddr,        // AHB address
  input  wire [1:0]       htrans,       // AHB transfer type
  input  wire             hwrite,       // AHB write
  input  wire [2:0]       hsize,        // AHB size
  input  wire [31:0]      hwdata,       // AHB write data
  input  wire             hready,       // AHB ready in
  output reg  [31:0]      hrdata,       // AHB read data
  output reg              hreadyout,    // AHB ready out
  output reg              hresp,        // AHB response, always OKAY
  input  wire             progBtn_b,    // Program button pin, low pressed
  input  wire [3:0]       rotarySel,    // Rotary selector pins
  input  wire             valveSense1,  // Link continuity to sense 1: open
  input  wire [LVL_W-1:0] sensorLevel,  // Level reading, core domain
  input  wire             sensorStable, // Reading settled
  output reg              pumpOut,      // Pump drive
  output reg              alarmOut,     // Seacock alarm
  output reg              statusLed,    // Status LED
  output reg              xferTx,       // Calibration transmit active
  output reg              xferRx,       // Calibration receive active
  output reg  [2:0]       netAddr,      // Network identity 2..5, else 0
  output reg              ultraMode     // Ultrasonic sensing configured
);
  // Sequencer states
  localparam S_IDLE  = 3'd0;
  localparam S_MEAS  = 3'd1;
  localparam S_BLINK = 3'd2;
  localparam S_WAIT  = 3'd3;
  localparam S_XFER  = 3'd4;
  localparam S_ARM   = 3'd5;

  // Pin synchronisers, one three-stage chain per pin
  reg [2:0]       btnSync_q;    // Button, high while pressed
  reg [2:0]       vlvSync_q;    // Valve sense
  reg [2:0]       selS1_q;      // Selector bit 0
  reg [2:0]       selS2_q;      // Selector bit 1
  reg [2:0]       selS3_q;      // Selector bit 2
  reg [2:0]       selS4_q;      // Selector bit 3
  // Filtered pin levels
  reg [3:0]       sel_q;        // Selector value
  reg             btn_q;        // Debounced button
  reg             btnPrev_q;    // Button one cycle ago
  reg             valveOpen_q;  // Filtered valve state
  // Counters
  reg [31:0]      debCnt_q;     // Debounce count
  reg [31:0]      holdCnt_q;    // Hold duration
  reg [31:0]      tick_q;       // Blink phase timer
  reg [31:0]      xferCnt_q;    // Copy duration
  reg             holdFired_q;  // Hold already acted on
  // Sequencer
  reg [2:0]       st_q;         // Current state
  reg [2:0]       step_q;       // Calibration point number
  reg [4:0]       blinks_q;     // Blinks still to give
  reg             ledAfter_q;   // LED lit after blinking
  reg             blinkPh_q;    // Blink phase
  reg             ledOn_q;      // LED before output flop
  reg [3:0]       doneSel_q;    // Selector whose copy has ended
  // Calibration points, empty to full
  reg [LVL_W-1:0] pt_q [0:4];
  // Bus side
  reg [31:0]      ctrl_q;       // Control word
  reg             errFlag_q;    // Sticky calibration error
  reg             doneFlag_q;   // Copy finished
  reg             pend_q;       // Data phase pending
  reg             pendW_q;      // Pending is a write
  reg [7:0]       pendA_q;      // Pending address
  integer         i;

  // Three-stage sync; second and third must agree.
  // No reset: the chains flush while reset is held.
  always @(posedge core_clk) begin
    btnSync_q <= {btnSync_q[1:0], ~progBtn_b};
    vlvSync_q <= {vlvSync_q[1:0], valveSense1};
    selS1_q   <= {selS1_q[1:0], rotarySel[0]};
    selS2_q   <= {selS2_q[1:0], rotarySel[1]};
    selS3_q   <= {selS3_q[1:0], rotarySel[2]};
    selS4_q   <= {selS4_q[1:0], rotarySel[3]};
  end

  // Button level is only trusted when the last two stages agree
  wire btnAgree = btnSync_q[2] == btnSync_q[1];

  // Debounce: level must stand DEB_CYC before accepted.
  // Contact bounce would otherwise look like a string of presses.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      btn_q       <= 1'b0;
      debCnt_q    <= 32'h0;
      btnPrev_q   <= 1'b0;
      valveOpen_q <= 1'b0;
      sel_q       <= 4'h0;
    end else begin
      btnPrev_q <= btn_q;
      if (!btnAgree || btnSync_q[1] == btn_q) begin
        debCnt_q <= 32'h0; // [R23]
      end else if (debCnt_q >= DEB_CYC - 1) begin
        btn_q    <= btnSync_q[1];
        debCnt_q <= 32'h0;
      end else begin
        debCnt_q <= debCnt_q + 32'h1;
      end
      // Valve and selector take a new level once two stages agree
      if (vlvSync_q[2] == vlvSync_q[1]) valveOpen_q <= vlvSync_q[1];
      if (selS1_q[2] == selS1_q[1]) sel_q[0] <= selS1_q[1];
      if (selS2_q[2] == selS2_q[1]) sel_q[1] <= selS2_q[1];
      if (selS3_q[2] == selS3_q[1]) sel_q[2] <= selS3_q[1];
      if (selS4_q[2] == selS4_q[1]) sel_q[3] <= selS4_q[1];
    end
  end

  // Press and release edges of the debounced button
  wire press  = btn_q & ~btnPrev_q;
  wire btnRel = ~btn_q & btnPrev_q;

  // Hold timer: one pulse after 3 s of continuous press.
  // Fired flag stops a long hold from acting twice.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      holdCnt_q   <= 32'h0;
      holdFired_q <= 1'b0;
    end else if (!btn_q) begin
      holdCnt_q   <= 32'h0;
      holdFired_q <= 1'b0;
    end else if (!holdFired_q) begin
      if (holdCnt_q >= HOLD_CYC - 1) holdFired_q <= 1'b1; // [R23]
      else holdCnt_q <= holdCnt_q + 32'h1;
    end
  end
  wire holdHit = btn_q & ~holdFired_q & (holdCnt_q >= HOLD_CYC - 1);

  // Blink period select: fast while measuring or copying, slow while counting
  wire [31:0] period = (st_q == S_MEAS || st_q == S_XFER) ? FAST_CYC : SLOW_CYC;
  wire        tickEn = (tick_q >= period - 1);

  // Acknowledge blinks for each five-point step
  function [4:0] fiveBlinks;
    input [2:0] s;
    case (s)
      3'd0: fiveBlinks = `TLC_BL_EMPTY5; // [R12]
      3'd1: fiveBlinks = `TLC_BL_QTR;    // [R13]
      3'd2: fiveBlinks = `TLC_BL_HALF;   // [R14]
      3'd3: fiveBlinks = `TLC_BL_TQTR;   // [R15]
      default: fiveBlinks = `TLC_BL_FULL5; // [R16]
    endcase
  endfunction

  // Mode decode and point slot for the current step
  wire       fiveMode = (sel_q == `TLC_SEL_FIVE);
  wire       lastStep = fiveMode ? (step_q == 3'd4) : (step_q == 3'd1);
  wire [2:0] slot     = fiveMode ? step_q : (step_q == 3'd0 ? 3'd0 : 3'd4);
  wire [2:0] oneSlot  = (sel_q == `TLC_SEL_LOW) ? 3'd0 : 3'd4;
  wire       copySel  = (sel_q == `TLC_SEL_TX) || (sel_q == `TLC_SEL_RX);

  // Point index of a pending bus write, from its word offset
  wire [7:0] ptOff = pendA_q - `TLC_PT0_ADDR;
  wire [2:0] ptIdx = ptOff[`TLC_WORD_SHIFT+2:`TLC_WORD_SHIFT];

  // Calibration sequencer.
  // A selector change mid-sequence does not abort it;
  // the user finishes or resets.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      st_q       <= S_IDLE;
      step_q     <= 3'd0;
      blinks_q   <= 5'd0;
      tick_q     <= 32'h0;
      ledAfter_q <= 1'b0;
      blinkPh_q  <= 1'b0;
      ledOn_q    <= 1'b0;
      xferCnt_q  <= 32'h0;
      errFlag_q  <= 1'b0;
      doneFlag_q <= 1'b0;
      doneSel_q  <= 4'h0;
      ultraMode  <= 1'b0;
      for (i = 0; i < 5; i = i + 1) pt_q[i] <= {LVL_W{1'b0}};
    end else begin
      // Free-running blink timer; states restart it as needed
      tick_q <= tickEn ? 32'h0 : tick_q + 32'h1;
      if (tickEn) blinkPh_q <= ~blinkPh_q;
      case (st_q)
        S_IDLE: begin
          ledOn_q <= 1'b0;
          step_q  <= 3'd0;
          if (holdHit) begin
            if (sel_q == `TLC_SEL_TWO || fiveMode) begin
              st_q <= S_MEAS; // [R4] [R12]
            end else if (sel_q == `TLC_SEL_LOW || sel_q == `TLC_SEL_HIGH) begin
              pt_q[oneSlot] <= sensorLevel; // [R9] [R10]
              ledOn_q       <= 1'b1;
              st_q          <= S_ARM;
            end else if (sel_q == `TLC_SEL_ULTRA) begin
              ultraMode  <= 1'b1; // [R20]
              blinks_q   <= `TLC_BL_ULTRA;
              ledAfter_q <= 1'b0;
              tick_q     <= 32'h0;
              blinkPh_q  <= 1'b0;
              st_q       <= S_BLINK;
            end
          end else if (copySel && !(doneFlag_q && doneSel_q == sel_q)) begin
            // One copy per selector setting, not a loop of copies
            xferCnt_q  <= 32'h0;
            doneFlag_q <= 1'b0;
            st_q       <= S_XFER; // [R17] [R18]
          end
        end
        S_MEAS: begin
          ledOn_q <= blinkPh_q; // [R5]
          if (sensorStable) begin
            pt_q[slot] <= sensorLevel;
            // LED dark at capture so the first blink is clean
            ledOn_q    <= 1'b0;
            tick_q     <= 32'h0;
            blinkPh_q  <= 1'b0;
            st_q       <= S_BLINK;
            ledAfter_q <= ~lastStep; // [R6] [R7] [R16]
            if (!fiveMode && lastStep && sensorLevel == pt_q[0]) begin
              blinks_q  <= `TLC_BL_ERR; // [R8]
              errFlag_q <= 1'b1;
            end else if (fiveMode) begin
              blinks_q <= fiveBlinks(step_q);
            end else begin
              blinks_q <= `TLC_BL_EMPTY2; // [R6] [R7]
            end
            if (!lastStep) step_q <= step_q + 3'd1;
          end
        end
        S_ARM: begin
          ledOn_q <= 1'b1;
          // Release of the capturing hold is skipped by its fired flag
          if (btnRel && holdFired_q == 1'b0) begin
            blinks_q   <= `TLC_BL_QUICK; // [R11]
            ledAfter_q <= 1'b0;
            tick_q     <= 32'h0;
            blinkPh_q  <= 1'b0;
            st_q       <= S_BLINK;
          end
        end
        S_BLINK: begin
          ledOn_q <= blinkPh_q;
          // A blink ends with the close of its lit phase
          if (tickEn && blinkPh_q) begin
            if (blinks_q == 5'd1) st_q <= ledAfter_q ? S_WAIT : S_IDLE;
            blinks_q <= blinks_q - 5'd1;
          end
        end
        S_WAIT: begin
          ledOn_q <= 1'b1;
          if (press) st_q <= S_MEAS;
        end
        S_XFER: begin
          ledOn_q <= blinkPh_q; // [R17] [R18]
          if (ctrl_q[`TLC_CTRL_XFERDONE] || xferCnt_q >= XFER_CYC - 1) begin
            doneFlag_q <= 1'b1;
            doneSel_q  <= sel_q;
            st_q       <= S_IDLE;
          end else begin
            xferCnt_q <= xferCnt_q + 32'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
      // Software may write a received calibration point
      if (pend_q && pendW_q && pendA_q >= `TLC_PT0_ADDR && pendA_q <= `TLC_PT4_ADDR
          && st_q == S_XFER && sel_q == `TLC_SEL_RX)
        pt_q[ptIdx] <= hwdata[LVL_W-1:0]; // [R18]
    end
  end

  // Pump interlock; a closed valve wins over any request
  always @(posedge core_clk) begin
    if (!rst_b) begin
      pumpOut  <= 1'b0;
      alarmOut <= 1'b0;
    end else begin
      pumpOut  <= ctrl_q[`TLC_CTRL_PUMPREQ] & valveOpen_q; // [R1] [R3]
      alarmOut <= ctrl_q[`TLC_CTRL_PUMPREQ] & ~valveOpen_q; // [R2]
    end
  end

  // Registered outputs
  always @(posedge core_clk) begin
    if (!rst_b) begin
      statusLed <= 1'b0;
      xferTx    <= 1'b0;
      xferRx    <= 1'b0;
      netAddr   <= 3'd0;
    end else begin
      statusLed <= ledOn_q;
      xferTx    <= (st_q == S_XFER) && sel_q == `TLC_SEL_TX; // [R17]
      xferRx    <= (st_q == S_XFER) && sel_q == `TLC_SEL_RX; // [R18]
      // Identity valid only for 2..5; master display unit polls it
      netAddr   <= (sel_q >= `TLC_SEL_ID_LO && sel_q <= `TLC_SEL_ID_HI) ?
                   sel_q[2:0] : 3'd0; // [R21] [R22]
    end
  end

  // AHB-Lite slave, zero wait states; write data in data phase.
  // Reads answer from the address phase, so no stall is needed.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      pend_q    <= 1'b0;
      pendW_q   <= 1'b0;
      pendA_q   <= 8'h00;
      ctrl_q    <= `TLC_CTRL_RESET;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      pend_q  <= hsel & hready & htrans[1];
      pendW_q <= hwrite;
      pendA_q <= haddr;
      if (pend_q && pendW_q && pendA_q == `TLC_CTRL_ADDR) ctrl_q <= hwdata;
      else if (st_q == S_IDLE) ctrl_q[`TLC_CTRL_XFERDONE] <= 1'b0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr)
          `TLC_CTRL_ADDR:   hrdata <= ctrl_q;
          `TLC_STATUS_ADDR: hrdata <= {16'h0, sel_q, 1'b0, st_q, ultraMode,
                                       doneFlag_q, errFlag_q, valveOpen_q,
                                       alarmOut, pumpOut, statusLed, ledOn_q};
          `TLC_PT0_ADDR: hrdata <= {{(32-LVL_W){1'b0}}, pt_q[0]};
          `TLC_PT1_ADDR: hrdata <= {{(32-LVL_W){1'b0}}, pt_q[1]};
          `TLC_PT2_ADDR: hrdata <= {{(32-LVL_W){1'b0}}, pt_q[2]};
          `TLC_PT3_ADDR: hrdata <= {{(32-LVL_W){1'b0}}, pt_q[3]};
          `TLC_PT4_ADDR: hrdata <= {{(32-LVL_W){1'b0}}, pt_q[4]};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // tlc_tank_cal
`default_nettype wire

/* tb/tlc_tank_cal_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tlc_tank_cal_checker (
  input wire logic       core_clk,    // Core clock
  input wire logic       rst_b,       // Sync reset, low
  input wire logic       hreadyout,   // Bus ready
  input wire logic       hresp,       // Bus response
  input wire logic       valveSense1, // Valve open
  input wire logic [3:0] rotarySel,   // Selector pins
  input wire logic       pumpOut,     // Pump drive
  input wire logic       alarmOut,    // Seacock alarm
  input wire logic       xferTx,      // Copy out
  input wire logic       xferRx,      // Copy in
  input wire logic [2:0] netAddr,     // Identity
  input wire logic       ultraMode    // Ultrasonic set
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Bus and pump; valve filter given six or eight edges of slack
  AST_READY: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  AST_PUMP_BLOCK: assert property ((!valveSense1)[*6] |-> !pumpOut)
    else $error("pump ran with valve closed");
  AST_ALARM_NOPUMP: assert property (alarmOut |-> !pumpOut)
    else $error("alarm raised with pump running");
  AST_OPEN_NOALARM: assert property (valveSense1[*8] |-> !alarmOut)
    else $error("alarm with valve open");
  // Identity follows a settled selector
  AST_ID: assert property (($stable(rotarySel) && rotarySel inside {[4'h2:4'h5]})[*8] |-> netAddr == rotarySel[2:0])
    else $error("identity not taken from selector");
  AST_ID_NONE: assert property ((rotarySel > 4'h5)[*8] |-> netAddr == 3'h0)
    else $error("identity set outside 2 to 5");
  // Copy direction tied to selector
  AST_TX_SEL: assert property ($rose(xferTx) |-> rotarySel == 4'hc)
    else $error("transmit started on wrong selector");
  AST_RX_SEL: assert property ($rose(xferRx) |-> rotarySel == 4'hd)
    else $error("receive started on wrong selector");
  AST_ONE_DIR: assert property (!(xferTx && xferRx))
    else $error("copy in both directions");
  AST_ULTRA_HOLD: assert property (ultraMode |=> ultraMode)
    else $error("ultrasonic setting lost");
endmodule // tlc_tank_cal_checker
`default_nettype wire

/* tb/tlc_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tlc_sensor_model #(
  parameter int SETTLE = 120
) (
  input  wire logic        core_clk,            // Core clock
  input  wire logic [11:0] target,              // Liquid level set by bench
  output logic      [11:0] sensorLevel  = '0,   // Reading
  output logic             sensorStable = 1'b1  // Reading settled
);
  int cnt = 0;
  // A level change sloshes for a while, so capture must wait
  always @(posedge core_clk) begin
    if (target !== sensorLevel) begin
      sensorLevel  <= target;
      cnt          <= SETTLE;
      sensorStable <= 1'b0;
    end else if (cnt > 0) cnt <= cnt - 1;
    else sensorStable <= 1'b1;
  end
endmodule // tlc_sensor_model
`default_nettype wire

/* tb/tlc_tank_cal_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlc_regs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h, expected %h", $time, (a), (e)); end end
module tlc_tank_cal_tb_top;
  logic        core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, progBtn_b = 1, valveSense1 = 1;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, netAddr;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, pumpOut, alarmOut, statusLed, xferTx, xferRx, ultraMode;
  logic        sensorStable;
  logic [3:0]  rotarySel = 4'h0;
  logic [11:0] target = 12'h000, sensorLevel;
  int          mismatches = 0, comparisons = 0, c;
  int          fiveBl[5] = '{6, 2, 3, 4, 5};
  // Half period of 20 ns
  always #20 core_clk = ~core_clk;
  tlc_tank_cal #(.HOLD_CYC(40), .DEB_CYC(4), .SLOW_CYC(8), .FAST_CYC(4), .XFER_CYC(200))
    tlc_tank_cal_i (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .progBtn_b, .rotarySel, .valveSense1,
    .sensorLevel, .sensorStable, .pumpOut, .alarmOut, .statusLed, .xferTx, .xferRx,
    .netAddr, .ultraMode);
  tlc_sensor_model tlc_sensor_model_i (.core_clk, .target, .sensorLevel, .sensorStable);
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One single transfer; data phase ends when ready is seen again
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      i = 0;
      do begin @(posedge core_clk); i++; end while (hreadyout !== 1'b1 && i < 20);
      if (i >= 20) begin mismatches++; tally_and_finish; end
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    end
    rd = hrdata;
  endtask
  task automatic sel(input logic [3:0] v);
    @(posedge core_clk);
    rotarySel <= v;
    tick(12);
  endtask
  // Rising edges of the LED, sampled clear of the clock edge
  task automatic cnt(input int n);
    logic p;
    c = 0;
    p = statusLed;
    repeat (n) begin @(posedge core_clk); #1; if (statusLed === 1'b1 && p === 1'b0) c++; p = statusLed; end
  endtask
  // Press n cycles at level lvl, expect nb blinks, then LED state (x skips it)
  task automatic step(input int n, input logic [11:0] lvl, input int nb, input logic ledEnd);
    int i;
    logic moved;
    moved = (lvl !== target);
    @(posedge core_clk);
    target <= lvl; progBtn_b <= 1'b0;
    tick(n);
    progBtn_b <= 1'b1;
    if (moved) begin cnt(16); `CHK(c >= 2, 1'b1) end
    i = 0;
    while (sensorStable !== 1'b1 && i < 500) begin @(posedge core_clk); i++; end
    if (i >= 500) begin mismatches++; tally_and_finish; end
    tick(2);
    cnt(nb * 16 + 40);
    `CHK(c, nb)
    if (ledEnd !== 1'bx) `CHK(statusLed, ledEnd)
  endtask
  initial begin
    tick(10);
    rst_b <= 1'b1;
    ahb(0, `TLC_CTRL_ADDR, 0); `CHK(rd, `TLC_CTRL_RESET)
    ahb(0, 8'h40, 0); `CHK(rd, 32'h0)
    valveSense1 <= 1'b0;
    ahb(1, `TLC_CTRL_ADDR, 32'h1); tick(10);
    `CHK(pumpOut, 1'b0)
    `CHK(alarmOut, 1'b1)
    valveSense1 <= 1'b1; tick(10);
    `CHK({pumpOut, alarmOut}, 2'b10)
    ahb(1, `TLC_CTRL_ADDR, 32'h0);
    $display("test pump interlock done");
    sel(`TLC_SEL_TWO);
    step(60, 12'd100, 3, 1'b1);
    step(20, 12'd300, 3, 1'b0);
    ahb(0, `TLC_PT0_ADDR, 0); `CHK(rd, 32'd100)
    ahb(0, `TLC_PT4_ADDR, 0); `CHK(rd, 32'd300)
    step(50, 12'd300, 3, 1'b1);
    step(10, 12'd300, 12, 1'bx);
    $display("test two point done");
    sel(`TLC_SEL_FIVE);
    for (int k = 0; k < 5; k++) step(k ? 20 : 60, 12'(10 * k + 10), fiveBl[k], k < 4);
    for (int k = 0; k < 5; k++) begin ahb(0, 8'(8 + 4 * k), 0); `CHK(rd, 32'(10 * k + 10)) end
    $display("test five point done");
    sel(`TLC_SEL_LOW);
    target <= 12'd70;
    tick(130);
    step(60, 12'd70, 0, 1'b1);
    step(20, 12'd70, 3, 1'b0);
    sel(`TLC_SEL_HIGH);
    target <= 12'd90;
    tick(130);
    step(60, 12'd90, 0, 1'b1);
    step(20, 12'd90, 3, 1'b0);
    ahb(0, `TLC_PT0_ADDR, 0); `CHK(rd, 32'd70)
    ahb(0, `TLC_PT4_ADDR, 0); `CHK(rd, 32'd90)
    $display("test single point done");
    sel(`TLC_SEL_ULTRA);
    step(50, 12'd90, 4, 1'b0);
    `CHK(ultraMode, 1'b1)
    sel(`TLC_SEL_TX); tick(10);
    `CHK(xferTx, 1'b1)
    tick(250);
    `CHK(xferTx, 1'b0)
    sel(`TLC_SEL_RX); tick(10);
    `CHK(xferRx, 1'b1)
    ahb(1, `TLC_CTRL_ADDR, 32'h2); tick(5);
    `CHK(xferRx, 1'b0)
    ahb(1, `TLC_CTRL_ADDR, 32'h0);
    sel(4'h3);
    `CHK(netAddr, 3'h3)
    $display("test copy and identity done");
    tally_and_finish;
  end
endmodule // tlc_tank_cal_tb_top
bind tlc_tank_cal tlc_tank_cal_checker tlc_tank_cal_checker_i (.core_clk, .rst_b, .hreadyout,
  .hresp, .valveSense1, .rotarySel, .pumpOut, .alarmOut, .xferTx, .xferRx, .netAddr, .ultraMode);
`default_nettype wire
